// [dv/dtoc_ctrl_checker.sv]
`timescale 1ns/1ps
`include "dtoc_regs.vh"

module dtoc_ctrl_checker
(
  input wire                  i_clk,
  input wire                  i_rst,
  input wire                  i_wr,
  input wire                  i_rd,
  input wire [7:0]            i_addr,
  input wire [7:0]            i_wdata,
  input wire [7:0]            o_rdata,
  input wire [47:0]           o_dac_code,
  input wire [3:0]            o_double_span,
  input wire                  o_internal_reference_select,
  input wire [1:0]            o_pair_buffer_enable,
  input wire [`DTOC_TAPS-1:0] o_tap_a
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence cfg_wr(logic [7:0] a);
    i_wr && i_addr == a;
  endsequence

  sequence gain_rd;
    i_rd && !i_wr && i_addr == `DTOC_ADDR_DACCFG;
  endsequence

  reset_state_a:
    assert property ($fell(i_rst) |-> o_dac_code == 48'h0
      && !o_internal_reference_select) else $error("bad reset state");
  ref_write_a:
    assert property (cfg_wr(`DTOC_ADDR_UPDREF) |=>
      o_internal_reference_select == $past(i_wdata[4]))
      else $error("reference select not loaded");
  ref_hold_a:
    assert property (!(i_wr && i_addr == `DTOC_ADDR_UPDREF) |=>
      $stable(o_internal_reference_select)) else $error("reference moved");
  gain_write_a:
    assert property (cfg_wr(`DTOC_ADDR_DACCFG) |=>
      o_double_span == $past(i_wdata[3:0])) else $error("gain not loaded");
  gain_hold_a:
    assert property (!(i_wr && i_addr == `DTOC_ADDR_DACCFG) |=>
      $stable(o_double_span)) else $error("gain moved");
  buffer_write_a:
    assert property (cfg_wr(`DTOC_ADDR_DACCFG) |=>
      o_pair_buffer_enable == ~$past(i_wdata[7:6]))
      else $error("buffer select not loaded");
  gain_readback_a:
    assert property (gain_rd |=> o_rdata[3:0] == $past(o_double_span))
      else $error("gain readback wrong");
  tap_onehot_a:
    assert property ($onehot(o_tap_a)) else $error("tap not one-hot");
  tap_code_a:
    assert property (o_tap_a[o_dac_code[11:0]])
      else $error("tap does not match code");
endmodule

bind dtoc_ctrl dtoc_ctrl_checker u_dtoc_ctrl_checker (
  .i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd),
  .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .o_dac_code(o_dac_code), .o_double_span(o_double_span),
  .o_internal_reference_select(o_internal_reference_select),
  .o_pair_buffer_enable(o_pair_buffer_enable), .o_tap_a(o_tap_a)
);

// [dv/dtoc_ctrl_test.sv]
`timescale 1ns/1ps
`include "dtoc_regs.vh"

module dtoc_ctrl_test;
  reg                   i_clk = 1'b0;
  reg                   i_rst = 1'b1;
  reg                   i_wr = 1'b0;
  reg                   i_rd = 1'b0;
  reg  [7:0]            i_addr = 8'h00;
  reg  [7:0]            i_wdata = 8'h00;
  reg                   i_strobe_n = 1'b1;
  wire [7:0]            o_rdata;
  wire [9:0]            int_temp;
  wire [9:0]            ext_temp;
  wire                  int_valid;
  wire                  ext_valid;
  wire [47:0]           o_dac_code;
  wire [3:0]            o_double_span;
  wire                  o_int_ref;
  wire [1:0]            o_buf_en;
  wire [`DTOC_TAPS-1:0] o_tap_a;
  wire [`DTOC_TAPS-1:0] o_tap_b;
  wire [`DTOC_TAPS-1:0] o_tap_c;
  wire [`DTOC_TAPS-1:0] o_tap_d;
  int                   num_errors = 0;
  int                   total_checks = 0;
  int                   cycles = 0;

  dtoc_ctrl u_dtoc_ctrl (
    .i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_dac_update_strobe_n(i_strobe_n),
    .i_int_temp(int_temp), .i_int_temp_valid(int_valid),
    .i_ext_temp(ext_temp), .i_ext_temp_valid(ext_valid),
    .o_dac_code(o_dac_code), .o_double_span(o_double_span),
    .o_internal_reference_select(o_int_ref),
    .o_pair_buffer_enable(o_buf_en), .o_tap_a(o_tap_a),
    .o_tap_b(o_tap_b), .o_tap_c(o_tap_c), .o_tap_d(o_tap_d)
  );

  dtoc_temp_model u_dtoc_temp_model (
    .i_clk(i_clk), .o_int_temp(int_temp), .o_int_valid(int_valid),
    .o_ext_temp(ext_temp), .o_ext_valid(ext_valid)
  );

  always #5 i_clk = ~i_clk;

  // --------------------------------
  // checking and bus access
  // --------------------------------
  task report_and_stop;
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // whole run needs under a hundred cycles; ceiling leaves ample margin
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      report_and_stop;
    end
  end

  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task chk_code(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %0t: code %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1 {i_wr, i_addr, i_wdata} = {1'b1, a, d};
    @(posedge i_clk);
    #1 i_wr = 1'b0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    #1 {i_rd, i_addr} = {1'b1, a};
    @(posedge i_clk);
    #1 i_rd = 1'b0;
    chk_byte(o_rdata, exp);
  endtask

  task therm(input logic ext, input logic [9:0] t, input logic [11:0] e);
    u_dtoc_temp_model.send(ext, t);
    repeat (2) @(posedge i_clk);
    #1 chk_code(ext ? o_dac_code[23:12] : o_dac_code[11:0], e);
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task test_reset;
    chk_code(o_dac_code[11:0], 12'h000);
    chk_byte({7'h0, o_tap_a[0]}, 8'h01);
    chk_byte({7'h0, o_int_ref}, 8'h00);
    rd_chk(8'h1a, 8'h00);
    rd_chk(8'h21, 8'hd8);
    rd_chk(8'h22, 8'hd8);
  endtask

  task test_config;
    wr(8'h1b, 8'h43);
    chk_byte({4'h0, o_double_span}, 8'h03);
    chk_byte({6'h0, o_buf_en}, 8'h02);
    rd_chk(8'h1b, 8'h43);
    wr(8'h1c, 8'h10);
    chk_byte({7'h0, o_int_ref}, 8'h01);
  endtask

  task test_update;
    wr(8'h10, 8'hab);
    wr(8'h11, 8'hc0);
    rd_chk(8'h10, 8'h00);
    chk_code(o_dac_code[11:0], 12'h000);
    @(posedge i_clk);
    #1 i_strobe_n = 1'b0;
    repeat (3) @(posedge i_clk);
    #1 i_strobe_n = 1'b1;
    repeat (2) @(posedge i_clk);
    #1 chk_code(o_dac_code[11:0], 12'habc);
    chk_byte({7'h0, o_tap_a[12'habc]}, 8'h01);
    rd_chk(8'h10, 8'hab);
    wr(8'h16, 8'h12);
    wr(8'h17, 8'h30);
    wr(8'h1c, 8'h08);
    repeat (2) @(posedge i_clk);
    #1 chk_code(o_dac_code[47:36], 12'h123);
    chk_byte({7'h0, o_tap_d[12'h123]}, 8'h01);
    chk_byte({7'h0, o_tap_c[12'h000]}, 8'h01);
    chk_byte({7'h0, o_int_ref}, 8'h00);
  endtask

  // offsets: 0xd8 is -40, 0x80 is -128, 0x0a is +10
  task test_thermal8;
    wr(8'h1a, 8'h60);
    therm(1'b0, 10'd100, 12'h410);
    therm(1'b0, 10'd108, 12'h430);
    wr(8'h22, 8'h0a);
    therm(1'b1, 10'h3b0, 12'h000);
    wr(8'h22, 8'h80);
    therm(1'b1, 10'h1fc, 12'hff0);
    chk_byte({7'h0, o_tap_b[12'hff0]}, 8'h01);
    therm(1'b1, 10'h1ff, 12'hff0);
  endtask

  task test_thermal10;
    wr(8'h1a, 8'h62);
    wr(8'h21, 8'h80);
    therm(1'b0, 10'h1ff, 12'hffc);
    wr(8'h21, 8'hd8);
    therm(1'b0, 10'd67, 12'h38c);
    therm(1'b0, 10'd68, 12'h390);
  endtask

  initial
  begin
    repeat (5) @(posedge i_clk);
    #1 i_rst = 1'b0;
    test_reset;
    test_config;
    test_update;
    test_thermal8;
    test_thermal10;
    report_and_stop;
  end
endmodule

// [dv/dtoc_temp_model.sv]
`timescale 1ns/1ps

module dtoc_temp_model
(
  input  wire       i_clk,
  output reg  [9:0] o_int_temp,
  output reg        o_int_valid,
  output reg  [9:0] o_ext_temp,
  output reg        o_ext_valid
);
  initial
  begin
    {o_int_temp, o_int_valid, o_ext_temp, o_ext_valid} = 22'h0;
  end

  // one-cycle result pulse; idle data is inverted so stale capture shows
  task send(input logic ext, input logic [9:0] t);
    @(posedge i_clk);
    #1;
    if (ext) {o_ext_temp, o_ext_valid} = {t, 1'b1};
    else {o_int_temp, o_int_valid} = {t, 1'b1};
    @(posedge i_clk);
    #1;
    if (ext) {o_ext_temp, o_ext_valid} = {~t, 1'b0};
    else {o_int_temp, o_int_valid} = {~t, 1'b0};
  endtask
endmodule

// [include/dtoc_regs.vh]
`ifndef DTOC_REGS_VH
`define DTOC_REGS_VH

// register offsets
`define DTOC_ADDR_CTRL3      8'h1A
`define DTOC_ADDR_DACCFG     8'h1B
`define DTOC_ADDR_UPDREF     8'h1C
`define DTOC_ADDR_INT_OFFS   8'h21
`define DTOC_ADDR_EXT_OFFS   8'h22
`define DTOC_ADDR_CODE_BASE  8'h10
`define DTOC_ADDR_CODE_LAST  8'h17

// reset values
`define DTOC_RST_CTRL3       8'h00
`define DTOC_RST_DACCFG      8'h00
`define DTOC_RST_UPDREF      8'h00
`define DTOC_RST_OFFS        8'hD8

// field positions
`define DTOC_CTRL3_TEN_BIT   1
`define DTOC_CTRL3_CHA_TH    5
`define DTOC_CTRL3_CHB_TH    6
`define DTOC_DACCFG_GAIN_LO  0
`define DTOC_DACCFG_BUF_AB   6
`define DTOC_DACCFG_BUF_CD   7
`define DTOC_UPDREF_INTREF   4
`define DTOC_UPDREF_SWUPD    3

// widths and limits
`define DTOC_CODE_W          12
`define DTOC_TAPS            4096
`define DTOC_TEMP_W          10
`define DTOC_TEN_MAX         11'h3FF
`define DTOC_EIGHT_MAX       11'h0FF

`endif

// [src/dtoc_ctrl.v]
// What this block does
// R01 - each channel takes an unsigned straight-binary code of 12, 10 or 8 bits
// R02 - the loaded code closes exactly one resistor-string tap
// R03 - each channel pair has its reference buffer enabled or bypassed
// R04 - internal or external reference held in update config; external at reset
// R05 - bit 4 of update config set selects the internal 2.28 V reference
// R06 - config bits 0 to 3 pick gain one or two per channel
// R07 - bits 0 and 1 give double span for thermal channels A and B
// R08 - ctrl3 bits 5 and 6 put channels A and B in thermal tracking
// R09 - thermal code recomputed and applied on each new temperature result
// R10 - thermal step is 1 degree in 8-bit, quarter degree in 10-bit
// R11 - thermal resolution is 8-bit after reset, ctrl3 bit 1 gives 10-bit except where RES_SEL is 0
// R12 - internal and external offsets hold zero-code temperature in twos complement
// R13 - each offset register is 8 bits, 1 degree resolution
// R14 - software encodes negative offsets with the sign bit set
// R15 - 8-bit thermal code is temperature minus offset in whole degrees
// R16 - 10-bit thermal code is temperature minus offset in quarter degrees
// R17 - tracking spans -128 to +127, default zero code at -40
// R18 - thermal code holds at top of span, never wraps
// R19 - temperature below the offset gives code zero
// R20 - written codes reach output and readback only after an update command
`timescale 1ns/1ps
`include "dtoc_regs.vh"

module dtoc_ctrl
#(
  parameter [1:0] RES_SEL = 2'd2   // 2: 12-bit, 1: 10-bit, 0: 8-bit
)
(
  input  wire                  i_clk,
  input  wire                  i_rst,
  input  wire                  i_wr,
  input  wire                  i_rd,
  input  wire [7:0]            i_addr,
  input  wire [7:0]            i_wdata,
  output reg  [7:0]            o_rdata,
  input  wire                  i_dac_update_strobe_n,
  input  wire [9:0]            i_int_temp,
  input  wire                  i_int_temp_valid,
  input  wire [9:0]            i_ext_temp,
  input  wire                  i_ext_temp_valid,
  output wire [47:0]           o_dac_code,
  output wire [3:0]            o_double_span,
  output wire                  o_internal_reference_select,
  output wire [1:0]            o_pair_buffer_enable,
  output wire [`DTOC_TAPS-1:0] o_tap_a,
  output wire [`DTOC_TAPS-1:0] o_tap_b,
  output wire [`DTOC_TAPS-1:0] o_tap_c,
  output wire [`DTOC_TAPS-1:0] o_tap_d
);

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  reg [7:0]  control_config_three_reg;
  reg [7:0]  dac_gain_buffer_config_reg;
  reg [7:0]  dac_update_reference_config_reg;
  reg [7:0]  internal_thermal_output_offset_reg;
  reg [7:0]  external_thermal_output_offset_reg;
  reg [11:0] input_code_reg [0:3];
  reg [11:0] dac_code_reg [0:3];
  reg [2:0]  strobe_sync_reg;
  reg        int_valid_reg;
  reg        ext_valid_reg;
  reg [9:0]  int_temp_reg;
  reg [9:0]  ext_temp_reg;

  wire       chan_a_thermal_select;
  wire       chan_b_thermal_select;
  wire       thermal_ten_bit_select;
  wire       strobe_fall;
  wire       sw_update;
  wire       update;
  wire [11:0] int_code;
  wire [11:0] ext_code;
  wire [11:0] code_mask;
  wire        code_addr;
  wire [1:0]  rd_chan;
  wire [11:0] rd_code;

  assign chan_a_thermal_select  =
    control_config_three_reg[`DTOC_CTRL3_CHA_TH];              // see R08
  assign chan_b_thermal_select  =
    control_config_three_reg[`DTOC_CTRL3_CHB_TH];              // see R08
  // 8-bit variant has no 10-bit thermal mode
  assign thermal_ten_bit_select =
    control_config_three_reg[`DTOC_CTRL3_TEN_BIT]
    && (RES_SEL != 2'd0);                                      // see R11

  // unused low bits masked so narrower variants stay straight binary
  assign code_mask = (RES_SEL == 2'd2) ? 12'hFFF
                   : (RES_SEL == 2'd1) ? 12'hFFC : 12'hFF0;    // see R01

  // ---------------------------------------------------------------
  // update command
  // ---------------------------------------------------------------
  // pin is asynchronous: two flops before the edge detector
  always @(posedge i_clk)
  begin
    if (i_rst)
      strobe_sync_reg <= 3'b111;
    else
      strobe_sync_reg <= {strobe_sync_reg[1:0], i_dac_update_strobe_n};
  end

  assign strobe_fall = strobe_sync_reg[2] & ~strobe_sync_reg[1];
  assign sw_update   = i_wr && (i_addr == `DTOC_ADDR_UPDREF)
                       && i_wdata[`DTOC_UPDREF_SWUPD];
  // one strobe for pin and register command: all channels not in thermal
  // tracking move together, so a pair never shows a half-updated setting
  assign update      = strobe_fall | sw_update;                // see R20

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      control_config_three_reg          <= `DTOC_RST_CTRL3;     // see R11
      dac_gain_buffer_config_reg        <= `DTOC_RST_DACCFG;
      dac_update_reference_config_reg   <= `DTOC_RST_UPDREF;    // see R04
      internal_thermal_output_offset_reg <= `DTOC_RST_OFFS;     // see R17
      external_thermal_output_offset_reg <= `DTOC_RST_OFFS;
    end
    else if (i_wr)
    begin
      case (i_addr)
        `DTOC_ADDR_CTRL3:    control_config_three_reg <= i_wdata;
        `DTOC_ADDR_DACCFG:   dac_gain_buffer_config_reg <= i_wdata;
        `DTOC_ADDR_UPDREF:   dac_update_reference_config_reg <= i_wdata;
        `DTOC_ADDR_INT_OFFS:
          internal_thermal_output_offset_reg <= i_wdata;       // see R12
        `DTOC_ADDR_EXT_OFFS:
          external_thermal_output_offset_reg <= i_wdata;       // see R13
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // thermal code computation
  // ---------------------------------------------------------------
  dtoc_thermal_code u_int_code
  (
    .i_temp    (int_temp_reg),
    .i_offset  (internal_thermal_output_offset_reg),
    .i_ten_bit (thermal_ten_bit_select),
    .i_res_sel (RES_SEL),
    .o_code    (int_code)
  );

  dtoc_thermal_code u_ext_code
  (
    .i_temp    (ext_temp_reg),
    .i_offset  (external_thermal_output_offset_reg),
    .i_ten_bit (thermal_ten_bit_select),
    .i_res_sel (RES_SEL),
    .o_code    (ext_code)
  );

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      int_valid_reg <= 1'b0;
      ext_valid_reg <= 1'b0;
      int_temp_reg  <= 10'h000;
      ext_temp_reg  <= 10'h000;
    end
    else
    begin
      int_valid_reg <= i_int_temp_valid;
      ext_valid_reg <= i_ext_temp_valid;
      // result stands only with its pulse, so it is taken here
      if (i_int_temp_valid)
        int_temp_reg <= i_int_temp;                            // see R09
      if (i_ext_temp_valid)
        ext_temp_reg <= i_ext_temp;                            // see R09
    end
  end

  // ---------------------------------------------------------------
  // input and output code registers, one per channel
  // ---------------------------------------------------------------
  // input code: codes 0x10..0x17 as msb/lsb pairs, msb at even address
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1)
    begin : g_chan
      wire       hit_lsb;
      wire       hit_msb;
      wire       thermal;
      wire [11:0] th_code;

      localparam [7:0] MSB_ADDR = `DTOC_ADDR_CODE_BASE + ch * 2;
      localparam [7:0] LSB_ADDR = `DTOC_ADDR_CODE_BASE + ch * 2 + 1;

      assign hit_msb = i_wr && (i_addr == MSB_ADDR);
      assign hit_lsb = i_wr && (i_addr == LSB_ADDR);
      assign thermal = (ch == 0) ? chan_a_thermal_select
                     : (ch == 1) ? chan_b_thermal_select : 1'b0;
      assign th_code = (ch == 0) ? int_code : ext_code;

      always @(posedge i_clk)
      begin
        if (i_rst)
        begin
          input_code_reg[ch] <= 12'h000;
          dac_code_reg[ch]   <= 12'h000;
        end
        else
        begin
          if (hit_msb)
            input_code_reg[ch] <= {i_wdata, input_code_reg[ch][3:0]};
          if (hit_lsb)
            input_code_reg[ch] <= {input_code_reg[ch][11:4], i_wdata[7:4]};
          // thermal mode overrides written code
          if (thermal)
          begin
            if ((ch == 0 && int_valid_reg) || (ch == 1 && ext_valid_reg))
              dac_code_reg[ch] <= th_code;                     // see R09
          end
          else if (update)
            dac_code_reg[ch] <= input_code_reg[ch] & code_mask; // see R20
        end
      end

      assign o_dac_code[ch*12 +: 12] = dac_code_reg[ch];       // see R01
    end
  endgenerate

  // ---------------------------------------------------------------
  // analog control outputs
  // ---------------------------------------------------------------
  // bit 0 and 1 double the thermal A and B spans too
  assign o_double_span = dac_gain_buffer_config_reg[3:0];      // see R06 R07
  assign o_internal_reference_select =
    dac_update_reference_config_reg[`DTOC_UPDREF_INTREF];      // see R05
  assign o_pair_buffer_enable =
    ~dac_gain_buffer_config_reg[`DTOC_DACCFG_BUF_CD:`DTOC_DACCFG_BUF_AB];
                                                               // see R03

  // ---------------------------------------------------------------
  // resistor string taps
  // ---------------------------------------------------------------
  // decoded from the applied code, so a pending write never moves a tap
  dtoc_tap_decode u_tap_a
  (
    .i_code (dac_code_reg[0]),
    .o_tap  (o_tap_a)
  );

  dtoc_tap_decode u_tap_b
  (
    .i_code (dac_code_reg[1]),
    .o_tap  (o_tap_b)
  );

  dtoc_tap_decode u_tap_c
  (
    .i_code (dac_code_reg[2]),
    .o_tap  (o_tap_c)
  );

  dtoc_tap_decode u_tap_d
  (
    .i_code (dac_code_reg[3]),
    .o_tap  (o_tap_d)
  );

  // ---------------------------------------------------------------
  // readback
  // ---------------------------------------------------------------
  // code block sits on an eight-byte boundary: channel in address
  // bits 2:1, msb at the even address
  assign code_addr = (i_addr >= `DTOC_ADDR_CODE_BASE)
                     && (i_addr <= `DTOC_ADDR_CODE_LAST);
  assign rd_chan   = i_addr[2:1];
  assign rd_code   = o_dac_code[rd_chan*`DTOC_CODE_W +: `DTOC_CODE_W];

  // code readback shows applied value, not pending write
  always @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        `DTOC_ADDR_CTRL3:    o_rdata <= control_config_three_reg;
        `DTOC_ADDR_DACCFG:   o_rdata <= dac_gain_buffer_config_reg;
        `DTOC_ADDR_UPDREF:   o_rdata <= dac_update_reference_config_reg;
        `DTOC_ADDR_INT_OFFS: o_rdata <= internal_thermal_output_offset_reg;
        `DTOC_ADDR_EXT_OFFS: o_rdata <= external_thermal_output_offset_reg;
        default:
          if (code_addr)
            o_rdata <= i_addr[0] ? {rd_code[3:0], 4'h0}
                                 : rd_code[11:4];              // see R20
          else
            o_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// [src/dtoc_tap_decode.v]
`timescale 1ns/1ps
`include "dtoc_regs.vh"

// one-hot tap select for the resistor string
module dtoc_tap_decode
(
  input  wire [11:0]          i_code,
  output wire [`DTOC_TAPS-1:0] o_tap
);

  genvar g;
  generate
    for (g = 0; g < `DTOC_TAPS; g = g + 1)
    begin : g_tap
      // genvar compares as a 32-bit integer
      assign o_tap[g] = ({20'h0_0000, i_code} == g);  // see R02
    end
  endgenerate

endmodule

// [src/dtoc_thermal_code.v]
`timescale 1ns/1ps
`include "dtoc_regs.vh"

// temperature minus offset, scaled to a 12-bit left-aligned code
module dtoc_thermal_code
(
  input  wire [9:0]  i_temp,
  input  wire [7:0]  i_offset,
  input  wire        i_ten_bit,
  input  wire [1:0]  i_res_sel,
  output reg  [11:0] o_code
);

  reg signed [11:0] diff_q;
  reg        [10:0] lim;
  reg        [9:0]  mag;
  reg               ten;

  // ---------------------------------------------------------------
  // arithmetic
  // ---------------------------------------------------------------
  // temp is twos complement quarter degrees; offset whole degrees
  always @*
  begin
    // 8-bit variant has no quarter-degree mode
    ten    = i_ten_bit && (i_res_sel != 2'd0);
    diff_q = {{2{i_temp[9]}}, i_temp} - {{2{i_offset[7]}}, i_offset, 2'b00};
    lim    = ten ? `DTOC_TEN_MAX : `DTOC_EIGHT_MAX;
    mag    = 10'h000;
    if (diff_q[11])
      mag = 10'h000;                                 // see R19
    else if (ten)
    begin
      if ({1'b0, diff_q[9:0]} > lim || diff_q[10])
        mag = lim[9:0];                              // see R18
      else
        mag = diff_q[9:0];                           // see R16
    end
    else
    begin
      if ({2'b00, diff_q[10:2]} > lim)
        mag = lim[9:0];                              // see R18
      else
        mag = {2'b00, diff_q[9:2]};                  // see R15
    end
    // always left-aligned, like written codes: an 8-bit step is 1/256
    // of the span on every variant, and a 10-bit step 1/1024 where RES_SEL is not 0
    if (ten)
      o_code = {mag, 2'b00};                         // see R10
    else
      o_code = {mag[7:0], 4'h0};
  end

endmodule
